// file: hppc_pkg.sv
package hppc_pkg;

  // ****************************************************************
  // Counts and timing
  // ****************************************************************
  localparam int unsigned NUM_PORTS     = 6;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Least overcurrent persistence before latching, in nanoseconds.
  localparam int unsigned OC_FILTER_NS  = 200;
  localparam int unsigned OC_FILTER_CYC =
    (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least time the upstream link stays dropped after a detect toggle.
  localparam int unsigned LINK_DROP_NS  = 500;
  localparam int unsigned LINK_DROP_CYC =
    (LINK_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Upstream link states
  // ****************************************************************
  typedef enum logic [2:0] {
    HPPC_UP_IDLE = 3'b001,
    HPPC_UP_DROP = 3'b010,
    HPPC_UP_LINK = 3'b100
  } hppc_up_e;

endpackage : hppc_pkg

// file: hppc_hub_port_power.sv
`timescale 1ns/1ns
module hppc_hub_port_power #(
  parameter int unsigned NPORT = hppc_pkg::NUM_PORTS
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic [NPORT-1:0] port_enable_i,
  input  wire logic [NPORT-1:0] host_port_off_i,
  input  wire logic [NPORT-1:0] oc_clear_i,
  input  wire logic             gang_mode_i,
  input  wire logic [NPORT-1:0] port_power_sense_pin_i,
  output logic      [NPORT-1:0] port_power_sense_pin_o,
  output logic      [NPORT-1:0] port_power_sense_pin_oe_o,
  output logic      [NPORT-1:0] port_pullup_en_o,
  output logic      [NPORT-1:0] reset_weak_pulldown_o,
  input  wire logic             shared_power_pin_i,
  output logic                  shared_power_pin_o,
  output logic                  shared_power_pin_oe_o,
  output logic                  shared_pullup_en_o,
  input  wire logic             upstream_power_detect_i,
  input  wire logic             orient_b_i,
  output logic                  upstream_link_en_o,
  output logic                  upstream_ss_tx_plus_orient_a_en_o,
  output logic                  upstream_ss_tx_plus_orient_b_en_o,
  output logic      [NPORT-1:0] oc_status_o,
  output logic                  oc_event_o
);

  localparam int unsigned FW = $clog2(hppc_pkg::OC_FILTER_CYC + 1);
  localparam logic [FW-1:0] FMAX = FW'(hppc_pkg::OC_FILTER_CYC);
  localparam int unsigned DW = $clog2(hppc_pkg::LINK_DROP_CYC + 1);
  localparam logic [DW-1:0] DMAX = DW'(hppc_pkg::LINK_DROP_CYC);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NPORT-1:0] pin_s1_r;
  logic [NPORT-1:0] pin_s2_r;
  logic             gang_s1_r;
  logic             gang_s2_r;
  logic             det_s1_r;
  logic             det_s2_r;
  logic             det_prev_r;

  // Two flops on every pin input; only the second stage is read.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      gang_s1_r <= 1'b0;
      gang_s2_r <= 1'b0;
      det_s1_r  <= 1'b0;
      det_s2_r  <= 1'b0;
    end else begin
      pin_s1_r  <= port_power_sense_pin_i;
      pin_s2_r  <= pin_s1_r;
      gang_s1_r <= shared_power_pin_i;
      gang_s2_r <= gang_s1_r;
      det_s1_r  <= upstream_power_detect_i;
      det_s2_r  <= det_s1_r;
    end
  end

  // ****************************************************************
  // Per-port overcurrent filter and pin control
  // ****************************************************************
  logic [NPORT-1:0] port_on_r;
  logic [NPORT-1:0] oc_lat_r;
  logic [NPORT-1:0] oc_new;
  logic [FW-1:0]    flt_r [NPORT];
  logic             gang_on;

  // In ganged mode the shared pin powers all ports while any port is on.
  assign gang_on = |port_on_r;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic sense_low;
    logic port_ok;
    // Ganged mode senses the shared pin instead of the port pin.
    assign sense_low = gang_mode_i ? !gang_s2_r : !pin_s2_r[p];
    assign port_ok   = port_enable_i[p] && !host_port_off_i[p] && !oc_lat_r[p];
    assign oc_new[p] = port_on_r[p] && sense_low && (flt_r[p] == FMAX - FW'(1));

    // The filter needs OC_FILTER_CYC consecutive low samples, so a glitch dies out.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        flt_r[p] <= '0;
      end else if (port_on_r[p] && sense_low && flt_r[p] != FMAX) begin
        flt_r[p] <= flt_r[p] + FW'(1);
      end else if (!(port_on_r[p] && sense_low)) begin
        flt_r[p] <= '0;
      end
    end

    // Latch wins over a simultaneous clear so no event is lost.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        oc_lat_r[p] <= 1'b0;
      end else if (oc_new[p]) begin
        oc_lat_r[p] <= 1'b1;
      end else if (oc_clear_i[p]) begin
        oc_lat_r[p] <= 1'b0;
      end
    end

    // Port state and pin drive; a latched fault also forces the port off.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        port_on_r[p]                 <= 1'b0;
        port_power_sense_pin_o[p]    <= 1'b0;
        port_power_sense_pin_oe_o[p] <= 1'b0;
        port_pullup_en_o[p]          <= 1'b0;
        reset_weak_pulldown_o[p]     <= 1'b1;
      end else begin
        port_on_r[p]                 <= port_ok && !oc_new[p];
        port_power_sense_pin_o[p]    <= 1'b0;
        port_power_sense_pin_oe_o[p] <= gang_mode_i || !(port_ok && !oc_new[p]);
        port_pullup_en_o[p]          <= !gang_mode_i && port_ok && !oc_new[p];
        reset_weak_pulldown_o[p]     <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Shared power pin and reporting
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shared_power_pin_o    <= 1'b0;
      shared_power_pin_oe_o <= 1'b0;
      shared_pullup_en_o    <= 1'b0;
      oc_status_o           <= '0;
      oc_event_o            <= 1'b0;
    end else begin
      shared_power_pin_o    <= 1'b0;
      shared_power_pin_oe_o <= gang_mode_i && !gang_on;
      shared_pullup_en_o    <= gang_mode_i && gang_on;
      oc_status_o           <= oc_lat_r | oc_new;
      oc_event_o            <= |oc_new;
    end
  end

  // ****************************************************************
  // Upstream link qualification
  // ****************************************************************
  hppc_pkg::hppc_up_e up_state_r;
  logic [DW-1:0]      drop_cnt_r;
  logic               det_edge;

  assign det_edge = det_s2_r ^ det_prev_r;

  // A detect toggle restarts the link only; port state is untouched.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_state_r <= hppc_pkg::HPPC_UP_IDLE;
      drop_cnt_r <= '0;
      det_prev_r <= 1'b0;
    end else begin
      det_prev_r <= det_s2_r;
      unique case (up_state_r)
        hppc_pkg::HPPC_UP_IDLE: begin
          if (det_s2_r) begin
            up_state_r <= hppc_pkg::HPPC_UP_LINK;
          end
        end
        hppc_pkg::HPPC_UP_LINK: begin
          if (det_edge || !det_s2_r) begin
            up_state_r <= hppc_pkg::HPPC_UP_DROP;
            drop_cnt_r <= '0;
          end
        end
        hppc_pkg::HPPC_UP_DROP: begin
          if (drop_cnt_r != DMAX) begin
            drop_cnt_r <= drop_cnt_r + DW'(1);
          end else begin
            up_state_r <= hppc_pkg::HPPC_UP_IDLE;
          end
        end
      endcase
    end
  end

  // Only the lane set matching the orientation is enabled; the other floats.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upstream_link_en_o                <= 1'b0;
      upstream_ss_tx_plus_orient_a_en_o <= 1'b0;
      upstream_ss_tx_plus_orient_b_en_o <= 1'b0;
    end else begin
      upstream_link_en_o <= (up_state_r == hppc_pkg::HPPC_UP_LINK) && det_s2_r;
      upstream_ss_tx_plus_orient_a_en_o <=
        (up_state_r == hppc_pkg::HPPC_UP_LINK) && !orient_b_i;
      upstream_ss_tx_plus_orient_b_en_o <=
        (up_state_r == hppc_pkg::HPPC_UP_LINK) && orient_b_i;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_oc_disables;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      oc_new[0] |=> !port_pullup_en_o[0] && port_power_sense_pin_oe_o[0] && oc_status_o[0];
  endproperty
  a_oc_disables: assert property (p_oc_disables) else $error("Overcurrent left port on.");

  property p_off_drives_low;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !port_enable_i[0] |=> port_power_sense_pin_oe_o[0] && !port_power_sense_pin_o[0];
  endproperty
  a_off_drives_low: assert property (p_off_drives_low) else $error("Disabled pin not low.");

  property p_on_released;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      port_pullup_en_o[0] |-> !port_power_sense_pin_oe_o[0];
  endproperty
  a_on_released: assert property (p_on_released) else $error("Pull-up while driving.");

  // A single low sample between two high ones, outside ganged mode.
  sequence s_glitch;
    (!gang_mode_i && pin_s2_r[0]) ##1 (!gang_mode_i && !pin_s2_r[0]) ##1 pin_s2_r[0];
  endsequence
  property p_glitch;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      s_glitch |-> !oc_new[0] && !$past(oc_new[0]);
  endproperty
  a_glitch: assert property (p_glitch) else $error("Glitch latched overcurrent.");

  // The pull-down falls at the first edge after release, so skip that edge.
  property p_no_pd_after_reset;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $past(arst_n_i) |-> reset_weak_pulldown_o == '0;
  endproperty
  a_no_pd_after_reset: assert property (p_no_pd_after_reset) else $error("Pull-down left on.");

  property p_link_needs_detect;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      upstream_link_en_o |-> $past(det_s2_r);
  endproperty
  a_link_needs_detect: assert property (p_link_needs_detect) else $error("Link without power.");

  property p_toggle_drops;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (up_state_r == hppc_pkg::HPPC_UP_LINK) && det_edge |-> ##2 !upstream_link_en_o;
  endproperty
  a_toggle_drops: assert property (p_toggle_drops) else $error("Toggle kept the link.");

  property p_one_orient;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !(upstream_ss_tx_plus_orient_a_en_o && upstream_ss_tx_plus_orient_b_en_o);
  endproperty
  a_one_orient: assert property (p_one_orient) else $error("Both lane sets on.");

  property p_gang_shared;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      gang_mode_i && $stable(gang_mode_i) |=> port_pullup_en_o == '0;
  endproperty
  a_gang_shared: assert property (p_gang_shared) else $error("Port pull-up in gang mode.");

endmodule : hppc_hub_port_power

// file: hppc_switch_model.sv
`timescale 1ns/1ns
// ****************************************************************
// External power switch and current monitor on one control line
// ****************************************************************
module hppc_switch_model #(
  parameter int unsigned N = 6
) (
  input  wire logic         clk_i,
  input  wire logic [N-1:0] oe_i,
  input  wire logic [N-1:0] pullup_i,
  input  wire logic [N-1:0] pulldown_i,
  input  wire logic [N-1:0] fault_i,
  output logic      [N-1:0] pin_o,
  output logic      [N-1:0] power_on_o
);
  logic wander_r = 1'b0;
  // An unpulled line flips every cycle, so a floating level is never read as valid.
  always_ff @(posedge clk_i) begin
    wander_r <= ~wander_r;
  end
  // Device low drive or a monitor fault wins over any pull resistor.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (oe_i[i] || fault_i[i])
        pin_o[i] = 1'b0;
      else if (pullup_i[i])
        pin_o[i] = 1'b1;
      else if (pulldown_i[i])
        pin_o[i] = 1'b0;
      else
        pin_o[i] = wander_r;
    end
    power_on_o = pin_o;  // The switch conducts while its enable line is high.
  end
endmodule : hppc_switch_model

// file: test_hub_port_power_control.sv
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench for the port power block
// ****************************************************************
module test_hub_port_power_control;
  logic clk = 1'b0, rst_n, gang, sh_fault, sh_in, sh_out, sh_oe, sh_pu;
  logic det, orient, link, a_en, b_en, ev;
  logic [5:0] en, off, clr, fault, pin, pout, oe, pu, pd, stat, power;
  int err_count = 0, total_checks = 0, ev_cnt = 0;
  // Half-period inversion gives the 50 ns system clock.
  always #25 clk = ~clk;
  hppc_hub_port_power DUT (
    .clk_sys_i(clk), .arst_n_i(rst_n), .port_enable_i(en), .host_port_off_i(off),
    .oc_clear_i(clr), .gang_mode_i(gang), .port_power_sense_pin_i(pin),
    .port_power_sense_pin_o(pout), .port_power_sense_pin_oe_o(oe),
    .port_pullup_en_o(pu), .reset_weak_pulldown_o(pd), .shared_power_pin_i(sh_in),
    .shared_power_pin_o(sh_out), .shared_power_pin_oe_o(sh_oe),
    .shared_pullup_en_o(sh_pu), .upstream_power_detect_i(det), .orient_b_i(orient),
    .upstream_link_en_o(link), .upstream_ss_tx_plus_orient_a_en_o(a_en),
    .upstream_ss_tx_plus_orient_b_en_o(b_en), .oc_status_o(stat), .oc_event_o(ev));
  hppc_switch_model #(.N(6)) ports_sw (.clk_i(clk), .oe_i(oe), .pullup_i(pu),
    .pulldown_i(pd), .fault_i(fault), .pin_o(pin), .power_on_o(power));
  hppc_switch_model #(.N(1)) gang_sw (.clk_i(clk), .oe_i(sh_oe), .pullup_i(sh_pu),
    .pulldown_i(1'b0), .fault_i(sh_fault), .pin_o(sh_in), .power_on_o());
  // Event pulses last one cycle, so each is counted at the edge after it rises.
  always @(posedge clk) begin
    if (ev === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic t_reset();
    tick(3);
    check("rst oe", oe, 6'h00);
    check("rst pulldown", pd, 6'h3F);
    check("rst pullup", pu, 6'h00);
    rst_n = 1'b1;
    tick(1);
    check("pulldown off", pd, 6'h00);
    check("off drive", oe, 6'h3F);
    check("off level", pout, 6'h00);
  endtask : t_reset
  task automatic t_enable();
    for (int i = 0; i < 6; i++) begin
      en = 6'(1 << i);
      tick(2);
      check("pullup", pu, en);
      check("oe", oe, ~en);
      check("power", power, en);
    end
    en = 6'h3F;
    off = 6'h05;
    tick(2);
    check("host off oe", oe, 6'h05);
    check("host off pullup", pu, 6'h3A);
    off = 6'h00;
    tick(2);
  endtask : t_enable
  task automatic t_glitch();
    fault = 6'h01;
    tick(1);
    fault = 6'h00;
    tick(10);
    check("glitch event", 6'(ev_cnt), 6'h00);
    en = 6'h3E;
    fault = 6'h01;
    tick(10);
    check("disabled fault", stat, 6'h00);
    fault = 6'h00;
    en = 6'h3F;
    tick(2);
  endtask : t_glitch
  task automatic t_overcurrent();
    fault = 6'h04;
    for (int k = 0; k < 12 && ev_cnt == 0; k++) tick(1);
    fault = 6'h00;
    tick(2);
    check("oc event", 6'(ev_cnt), 6'h01);
    check("oc status", stat, 6'h04);
    check("oc port off", oe, 6'h04);
    check("oc pullup", pu, 6'h3B);
    clr = 6'h04;
    tick(1);
    clr = 6'h00;
    tick(2);
    check("cleared", stat, 6'h00);
    check("repowered", pu, 6'h3F);
  endtask : t_overcurrent
  task automatic t_link();
    det = 1'b1;
    for (int k = 0; k < 8 && link !== 1'b1; k++) tick(1);
    check("link up", 6'(link), 6'h01);
    tick(1);
    check("lane a", 6'({a_en, b_en}), 6'h02);
    orient = 1'b1;
    tick(2);
    check("lane b", 6'({a_en, b_en}), 6'h01);
    det = 1'b0;
    tick(1);
    det = 1'b1;
    tick(5);
    check("link dropped", 6'(link), 6'h00);
    check("ports kept", pu, 6'h3F);
    for (int k = 0; k < 20 && link !== 1'b1; k++) tick(1);
    check("link back", 6'(link), 6'h01);
    det = 1'b0;
    tick(16);
    check("no power", 6'(link), 6'h00);
  endtask : t_link
  task automatic t_gang();
    int c0;
    gang = 1'b1;
    tick(3);
    check("gang ports", oe, 6'h3F);
    check("gang pullup", 6'(sh_pu), 6'h01);
    c0 = ev_cnt;
    sh_fault = 1'b1;
    for (int k = 0; k < 12 && ev_cnt == c0; k++) tick(1);
    check("gang event", 6'(ev_cnt - c0), 6'h01);
    check("gang off oe", 6'(sh_oe), 6'h01);
    check("gang off pullup", 6'(sh_pu), 6'h00);
    check("gang off level", 6'(sh_out), 6'h00);
    sh_fault = 1'b0;
    clr = 6'h3F;
    tick(1);
    clr = 6'h00;
    gang = 1'b0;
  endtask : t_gang
  // Main sequence: reset held three cycles, then one task per behaviour.
  initial begin
    {en, off, clr, fault} = '0;
    {gang, det, orient, sh_fault, rst_n} = '0;
    t_reset();
    t_enable();
    t_glitch();
    t_overcurrent();
    t_link();
    t_gang();
    results();
  end
  // Watchdog well beyond the at most 129 cycles the tasks need.
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : test_hub_port_power_control
